//--- design/mhcs_edge_detect.sv
// Falling-edge detector for the active carrier
`timescale 1ns/1ps
module mhcs_edge_detect (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, low
   input wire logic sig, // Conditioned carrier
   output logic fall // One-cycle falling-edge pulse
);
   // ==========================================================
   // State
   typedef struct packed {
      logic last; // Carrier last cycle
   } mhcs_ed_state_type;
   mhcs_ed_state_type state_reg, state_next;
   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.last = sig;
   end
   // Register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign fall = state_reg.last & ~sig;
endmodule // mhcs_edge_detect

//--- design/mhcs_source_mux.sv
// Carrier source multiplexer of the high-carrier select
`timescale 1ns/1ps
module mhcs_source_mux
   import mhcs_pkg::*;
#(
   parameter int NUM_SRC = MHCS_NUM_SRC
) (
   input wire logic [NUM_SRC-1:0] src_in, // Candidate carriers by code
   input wire logic [3:0] sel, // Source code
   output logic carrier // Selected carrier
);
   // ==========================================================
   // Selection, reserved codes give a low carrier
   always_comb begin
      carrier = 1'b0;
      if (sel < 4'(NUM_SRC)) begin
         carrier = src_in[sel[2:0]];
      end
   end
endmodule // mhcs_source_mux

//--- design/mhcs_top.sv
// High-carrier selection, conditioning and AXI4-Lite control of the modulator
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mhcs_top
   import mhcs_pkg::*;
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, low
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic carrier_pin1, // First carrier port pin
   input wire logic carrier_pin2, // Second carrier port pin
   input wire logic reference_clock_output, // Reference clock signal
   input wire logic capture_pwm_unit_one, // PWM unit one output
   input wire logic capture_pwm_unit_two, // PWM unit two output
   input wire logic capture_pwm_unit_three, // PWM unit three output
   input wire logic capture_pwm_unit_four, // PWM unit four output
   input wire logic switch_request, // Modulation source wants high carrier
   output logic high_carrier, // Conditioned selected carrier
   output logic high_carrier_active, // Output now uses high carrier
   output logic high_carrier_pin_output_disable // Pin driver disable
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] ctrl; // Control register
      logic aw_held; // Address captured
      logic [3:0] aw_addr; // Captured write address
      logic w_held; // Data captured
      logic [7:0] w_data; // Captured write byte
      logic w_strb; // Captured lane 0 strobe
      logic bvalid; // Write response pending
      logic [1:0] bresp; // Write response code
      logic rvalid; // Read data pending
      logic [1:0] rresp; // Read response code
      logic [31:0] rdata; // Read data
      logic active; // Switched to high carrier
      logic carrier; // Registered carrier
   } mhcs_state_type;
   mhcs_state_type state_reg, state_next;
   logic [MHCS_NUM_SRC-1:0] src_vec; // Sources by code
   logic raw_carrier; // Mux output
   logic cond_carrier; // After polarity
   logic carrier_fall; // Falling edge pulse
   logic [3:0] code; // Source code field
   // ==========================================================
   // Source routing
   assign code = state_reg.ctrl[3:0];
   // Bit n carries code n; code 0 routes nothing and stays low
   assign src_vec = {capture_pwm_unit_four, capture_pwm_unit_three,
                     capture_pwm_unit_two, capture_pwm_unit_one,
                     reference_clock_output, carrier_pin2, carrier_pin1, 1'b0};
   mhcs_source_mux #(
      .NUM_SRC(MHCS_NUM_SRC)
   ) u_mux (
      .src_in(src_vec),
      .sel(code),
      .carrier(raw_carrier)
   );
   // Polarity
   assign cond_carrier = raw_carrier ^ state_reg.ctrl[MHCS_POL_BIT];
   mhcs_edge_detect u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .sig(cond_carrier),
      .fall(carrier_fall)
   );
   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.carrier = cond_carrier;
      // Switch handling
      if (!switch_request) begin
         state_next.active = 1'b0;
      end else if (!state_reg.ctrl[MHCS_SYNC_BIT]) begin
         state_next.active = 1'b1;
      end else if (carrier_fall) begin
         state_next.active = 1'b1;
      end
      // Write channels
      if (s_axi_awvalid && !state_reg.aw_held) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state_reg.w_held) begin
         state_next.w_held = 1'b1;
         state_next.w_data = s_axi_wdata[7:0];
         state_next.w_strb = s_axi_wstrb[0];
      end
      // Commit write once both halves held and no response pending
      if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.bvalid = 1'b1;
         if (state_reg.aw_addr == MHCS_CTRL_OFFSET) begin
            state_next.bresp = MHCS_RESP_OKAY;
            if (state_reg.w_strb) begin
               state_next.ctrl = state_reg.w_data & MHCS_CTRL_WMASK;
            end
         end else if (state_reg.aw_addr == MHCS_STAT_OFFSET) begin
            state_next.bresp = MHCS_RESP_OKAY; // Read-only, write ignored
         end else begin
            state_next.bresp = MHCS_RESP_SLVERR;
         end
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end
      // Read channel
      if (s_axi_arvalid && !state_reg.rvalid) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = MHCS_RESP_OKAY;
         unique case (s_axi_araddr)
            MHCS_CTRL_OFFSET: begin
               state_next.rdata = {24'h000000, state_reg.ctrl};
            end
            MHCS_STAT_OFFSET: begin
               state_next.rdata = {29'h00000000, raw_carrier, state_reg.carrier,
                                   state_reg.active};
            end
            default: begin
               state_next.rdata = 32'h00000000;
               state_next.rresp = MHCS_RESP_SLVERR;
            end
         endcase
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
   end
   // Register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   // ==========================================================
   // Outputs
   assign s_axi_awready = !state_reg.aw_held;
   assign s_axi_wready = !state_reg.w_held;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rresp = state_reg.rresp;
   assign s_axi_rdata = state_reg.rdata;
   assign high_carrier = state_reg.carrier;
   assign high_carrier_active = state_reg.active;
   assign high_carrier_pin_output_disable = state_reg.ctrl[MHCS_ODIS_BIT];
endmodule // mhcs_top

//--- inc/mhcs_pkg.sv
// Package with offsets, field layouts, reset values and source codes of the high-carrier select
package mhcs_pkg;
   // ==========================================================
   // Register map (byte addresses on the AXI4-Lite slave)
   localparam logic [3:0] MHCS_CTRL_OFFSET = 4'h0; // High-carrier control word
   localparam logic [3:0] MHCS_STAT_OFFSET = 4'h4; // Live status word
   // ==========================================================
   // Control field positions
   localparam int MHCS_ODIS_BIT = 7; // Pin output disable
   localparam int MHCS_POL_BIT = 6; // Carrier invert
   localparam int MHCS_SYNC_BIT = 5; // Falling-edge sync enable
   localparam logic [7:0] MHCS_CTRL_WMASK = 8'hEF; // Bit 4 reads zero
   localparam logic [7:0] MHCS_CTRL_RESET = 8'h00; // Control after reset
   // ==========================================================
   // Source codes
   localparam logic [3:0] MHCS_SRC_NONE = 4'h0; // Nothing routed
   localparam logic [3:0] MHCS_SRC_PIN1 = 4'h1; // First carrier pin
   localparam logic [3:0] MHCS_SRC_PIN2 = 4'h2; // Second carrier pin
   localparam logic [3:0] MHCS_SRC_REFCLK = 4'h3; // Reference clock output
   localparam logic [3:0] MHCS_SRC_PWM1 = 4'h4; // First unit
   localparam logic [3:0] MHCS_SRC_PWM2 = 4'h5; // Second unit
   localparam logic [3:0] MHCS_SRC_PWM3 = 4'h6; // Third unit
   localparam logic [3:0] MHCS_SRC_PWM4 = 4'h7; // Fourth unit
   localparam int MHCS_NUM_SRC = 8; // Codes 0..7 are wired
   // ==========================================================
   // AXI responses
   localparam logic [1:0] MHCS_RESP_OKAY = 2'h0; // Normal answer
   localparam logic [1:0] MHCS_RESP_SLVERR = 2'h2; // Unmapped address
endpackage

//--- tb/mhcs_carrier_model.sv
// Carrier sources around the high-carrier select
`timescale 1ns/1ps
module mhcs_carrier_model (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   output logic [6:0] carriers // Units four..one, refclk, pin2, pin1
);
   logic [4:0] cnt_reg; // Shared time base
   // Units always run as PWM outputs; four at quarter duty, three at 5/8, two and one both at half duty
   always_ff @(posedge aclk) begin
      cnt_reg <= aresetn ? cnt_reg + 5'h01 : 5'h00;
      carriers <= {cnt_reg[1:0] == 2'h0, cnt_reg[2:0] < 3'h5, cnt_reg[3], cnt_reg[4],
         cnt_reg[0], cnt_reg[2], cnt_reg[1] ^ cnt_reg[3]};
   end
endmodule // mhcs_carrier_model

//--- tb/mhcs_checker.sv
// Port checker of the high-carrier select
`timescale 1ns/1ps
module mhcs_checker
   import mhcs_pkg::*;
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic [3:0] s_axi_awaddr, // Address
   input wire logic s_axi_awvalid, // Valid
   input wire logic s_axi_awready, // Ready
   input wire logic [31:0] s_axi_wdata, // Data
   input wire logic s_axi_wvalid, // Valid
   input wire logic s_axi_wready, // Ready
   input wire logic s_axi_bvalid, // Valid
   input wire logic s_axi_bready, // Ready
   input wire logic carrier_pin1, // Pin
   input wire logic capture_pwm_unit_two, // Unit
   input wire logic capture_pwm_unit_three, // Unit
   input wire logic capture_pwm_unit_four, // Unit
   input wire logic switch_request, // Request
   input wire logic high_carrier, // Carrier
   input wire logic high_carrier_active // Switched
);
   // ==========
   // Shadow of the control word
   logic [3:0] addr_reg; // Captured address
   logic [7:0] data_reg; // Captured byte
   logic [7:0] ctrl_reg; // Shadow control
   logic [1:0] age_reg; // Quiet cycles
   logic q; // Shadow trusted
   logic aw_hs; // Address taken
   logic w_hs; // Data taken
   assign aw_hs = s_axi_awvalid && s_axi_awready;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign q = age_reg == 2'h3;
   // Rebuild control, trust it only after write traffic is over
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= MHCS_CTRL_RESET;
         age_reg <= 2'h0;
      end else begin
         if (aw_hs) addr_reg <= s_axi_awaddr;
         if (w_hs) data_reg <= s_axi_wdata[7:0];
         if (s_axi_bvalid && s_axi_bready && addr_reg == MHCS_CTRL_OFFSET)
            ctrl_reg <= data_reg & MHCS_CTRL_WMASK;
         if (aw_hs || w_hs || s_axi_bvalid) age_reg <= 2'h0;
         else if (!q) age_reg <= age_reg + 2'h1;
      end
   end
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_unit_four_route: assert property (q && ctrl_reg[3:0] == 4'h7 |=>
      high_carrier == ($past(capture_pwm_unit_four) ^ ctrl_reg[6])) else $error("bad unit four");
   chk_unit_three_route: assert property (q && ctrl_reg[3:0] == 4'h6 |=>
      high_carrier == ($past(capture_pwm_unit_three) ^ ctrl_reg[6])) else $error("bad unit three");
   chk_unit_two_route: assert property (q && ctrl_reg[3:0] == 4'h5 |=>
      high_carrier == ($past(capture_pwm_unit_two) ^ ctrl_reg[6])) else $error("bad unit two");
   chk_carrier_invert: assert property (q && ctrl_reg[3:0] == MHCS_SRC_PIN1 |=>
      high_carrier == ($past(carrier_pin1) ^ ctrl_reg[6])) else $error("bad polarity");
   chk_direct_switch: assert property (q && switch_request && !ctrl_reg[5] |=>
      high_carrier_active) else $error("switch not immediate");
   chk_request_drop: assert property (q && !switch_request |=> !high_carrier_active)
      else $error("switch without request");
   chk_sync_wait: assert property (q && ctrl_reg[5] && $rose(high_carrier_active) |->
      $fell(high_carrier)) else $error("switch without falling edge");
endmodule // mhcs_checker

//--- tb/mhcs_top_tb.sv
// Self-checking bench of the high-carrier select
`timescale 1ns/1ps
module mhcs_top_tb
   import mhcs_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, switch_request;
   logic carrier_pin1, carrier_pin2, reference_clock_output, capture_pwm_unit_one, high_carrier;
   logic capture_pwm_unit_two, capture_pwm_unit_three, capture_pwm_unit_four;
   logic high_carrier_active, high_carrier_pin_output_disable;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [33:0] exp_q[$]; // Expected bus answers
   int mismatches, checks;
   mhcs_top u_dut (.*);
   mhcs_carrier_model u_src (.aclk(aclk), .aresetn(aresetn), .carriers({capture_pwm_unit_four,
      capture_pwm_unit_three, capture_pwm_unit_two, capture_pwm_unit_one,
      reference_clock_output, carrier_pin2, carrier_pin1}));
   // Clock of 8 ns
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[0];
   endfunction
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write one control byte and expect an OKAY answer
   task automatic wr(input logic [7:0] d);
      @(posedge aclk);
      exp_q.push_back({MHCS_RESP_OKAY, 32'h0});
      s_axi_awaddr <= MHCS_CTRL_OFFSET;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   // Read one word, noting its expected answer
   task automatic rd(input logic [3:0] a, input logic [33:0] exp);
      @(posedge aclk);
      exp_q.push_back(exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Compares each bus answer with the oldest note
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      #48000;
      mismatches++;
      conclude();
   end
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, switch_request} = 41'h0;
      s_axi_wstrb = 4'hF;
      seed = 32'd25;
      mismatches = 0;
      checks = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(MHCS_CTRL_OFFSET, {MHCS_RESP_OKAY, 24'h0, MHCS_CTRL_RESET});
      rd(4'h8, {MHCS_RESP_SLVERR, 32'h0});
      wr(8'hFF);
      rd(MHCS_CTRL_OFFSET, {MHCS_RESP_OKAY, 24'h0, MHCS_CTRL_WMASK});
      chk({33'h0, high_carrier_pin_output_disable}, 34'h1);
      $display("test registers done");
      // Codes 1, 5, 6 and 7 in both polarities, random requests
      for (int i = 0; i < 8; i++) begin
         wr({1'b0, i[2], 2'h0, (i[1:0] == 2'h0) ? MHCS_SRC_PIN1 : {2'h1, i[1:0]}});
         repeat (24) @(posedge aclk) switch_request <= rnd();
      end
      $display("test routing done");
      // Synchronized switching waits for a falling edge
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk) switch_request <= 1'b0;
         wr({1'b0, i[0], 6'h27});
         repeat (2 + i) @(posedge aclk);
         switch_request <= 1'b1;
         do @(negedge aclk); while (high_carrier_active !== 1'b1);
         chk({33'h0, high_carrier}, 34'h0);
      end
      @(posedge aclk) switch_request <= 1'b0;
      repeat (2) @(negedge aclk);
      chk({33'h0, high_carrier_active}, 34'h0);
      chk({33'h0, high_carrier_pin_output_disable}, 34'h0);
      $display("test sync done");
      conclude();
   end
endmodule // mhcs_top_tb
bind mhcs_top mhcs_checker u_chk (.*);
